// ===== logic/gofc_core.sv
`timescale 1ns/1ps
// Contract
// [RL1] send-value: transmit value-write, ignore send condition
// [RL2] request-value: transmit value-read telegram for object
// [RL3] read-flags returns object's status byte
// [RL4] status byte: tmo7, 0,0, chg4, upd3, rd2, tx1:0
// [RL5] tx field reports transmission state
// [RL6] read flag triggers read request with tx
// [RL7] received value sets update flag
// [RL8] changed value sets value-changed flag
// [RL9] no receive within timeout sets timeout flag
// [RL10] all-update query returns packed update flags
// [RL11] all-changed query returns packed changed flags
// [RL12] all-timeout query returns packed timeout flags
// [RL13] object-data read clears update flag
// [RL14] pack one bit per object, object0 lsb
// [RL15] echo command and parameters then return value
module gofc_core (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire gofc_pkg::gofc_rx_type  cmd_in,
    output logic                        cmd_ready,
    output gofc_pkg::gofc_resp_type     resp_out,
    input  wire logic                   resp_ack,
    output gofc_pkg::gofc_tx_type       tx_out,
    input  wire logic                   tx_ready,
    input  wire logic                   tx_done,
    input  wire logic                   tx_fail,
    input  wire logic                   bus_rx_valid,
    input  wire logic [3:0]             bus_rx_index,
    input  wire logic [7:0]             bus_rx_value
);
    import gofc_pkg::*;

    gofc_state_all_type s_q;
    gofc_state_all_type s_d;

    function automatic logic [NUM_OBJ-1:0] pack_bit(
        input logic [NUM_OBJ-1:0][7:0] f,
        input int                      b
    );
        logic [NUM_OBJ-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_OBJ; i++) begin
            r[i] = f[i][b]; // [RL14]
        end
        return r;
    endfunction

    assign cmd_ready = (s_q.state == GOFC_ST_IDLE) && !s_q.tx.valid;
    assign resp_out  = s_q.resp;
    assign tx_out    = s_q.tx;

    always_comb begin
        logic [IDX_W-1:0] oi;
        oi  = cmd_in.object_index;
        s_d = s_q;

        // tx handshake and state report
        if (s_q.tx.valid && tx_ready) begin
            s_d.tx.valid = 1'b0;
            s_d.flags[s_q.tx.object_index][TX_HI:TX_LO] = TX_BUSY; // [RL5]
        end
        if (tx_done || tx_fail) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                if (s_q.flags[i][TX_HI:TX_LO] == TX_BUSY) begin
                    s_d.flags[i][TX_HI:TX_LO] = tx_fail ? TX_ERR : TX_IDLE; // [RL5]
                    s_d.flags[i][BIT_RD] = 1'b0;
                end
            end
        end

        // pending read flag launches a read telegram when tx is free
        if (!s_d.tx.valid) begin
            for (int i = NUM_OBJ - 1; i >= 0; i--) begin
                if (s_d.flags[i][BIT_RD] && s_d.flags[i][TX_HI:TX_LO] == TX_REQ) begin
                    s_d.tx.valid        = 1'b1; // [RL6] [RL2]
                    s_d.tx.read_req     = 1'b1;
                    s_d.tx.object_index = IDX_W'(i);
                    s_d.tx.value        = 8'h00;
                end
            end
        end

        // timeout counters
        for (int i = 0; i < NUM_OBJ; i++) begin
            if (s_q.tmo_cnt[i] != '0) begin
                s_d.tmo_cnt[i] = s_q.tmo_cnt[i] - 1'b1;
            end else begin
                s_d.flags[i][BIT_TMO] = 1'b1; // [RL9]
            end
        end

        if (resp_ack && s_q.state == GOFC_ST_RESP) begin
            s_d.resp.valid = 1'b0;
            s_d.state      = GOFC_ST_IDLE;
        end

        if (cmd_in.valid && cmd_ready) begin
            s_d.resp.valid        = 1'b1; // [RL15]
            s_d.resp.cmd          = cmd_in.cmd;
            s_d.resp.object_index = oi;
            s_d.resp.data         = '0;
            s_d.state             = GOFC_ST_RESP;
            case (cmd_in.cmd)
                GOFC_CMD_SEND_VALUE: begin
                    s_d.tx.valid        = 1'b1; // [RL1]
                    s_d.tx.read_req     = 1'b0;
                    s_d.tx.object_index = oi;
                    s_d.tx.value        = s_q.values[oi];
                    s_d.flags[oi][TX_HI:TX_LO] = TX_REQ; // [RL5]
                end
                GOFC_CMD_REQ_VALUE: begin
                    s_d.flags[oi][BIT_RD] = 1'b1; // [RL2] [RL6]
                    s_d.flags[oi][TX_HI:TX_LO] = TX_REQ;
                end
                GOFC_CMD_GET_FLAGS: begin
                    s_d.resp.data = NUM_OBJ'(s_q.flags[oi]); // [RL3]
                end
                GOFC_CMD_ALL_UPD: begin
                    s_d.resp.data = pack_bit(s_q.flags, BIT_UPD); // [RL10]
                end
                GOFC_CMD_ALL_CHG: begin
                    s_d.resp.data = pack_bit(s_q.flags, BIT_CHG); // [RL11]
                end
                GOFC_CMD_ALL_TMO: begin
                    s_d.resp.data = pack_bit(s_q.flags, BIT_TMO); // [RL12]
                end
                GOFC_CMD_DATA_READ: begin
                    s_d.resp.data = NUM_OBJ'(s_q.values[oi]);
                    s_d.flags[oi][BIT_UPD] = 1'b0; // [RL13]
                end
                default: begin
                    s_d.resp.data = '0;
                end
            endcase
        end

        // bus receive after host clears so set wins
        if (bus_rx_valid) begin
            s_d.flags[bus_rx_index][BIT_UPD] = 1'b1; // [RL7]
            if (bus_rx_value != s_q.values[bus_rx_index]) begin
                s_d.flags[bus_rx_index][BIT_CHG] = 1'b1; // [RL8]
            end
            s_d.flags[bus_rx_index][BIT_TMO] = 1'b0;
            s_d.values[bus_rx_index]         = bus_rx_value;
            s_d.tmo_cnt[bus_rx_index]        = TMO_RESET;
        end

        for (int i = 0; i < NUM_OBJ; i++) begin
            s_d.flags[i][6:5] = 2'h0; // [RL4]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            for (int i = 0; i < NUM_OBJ; i++) begin
                s_q.tmo_cnt[i] <= TMO_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== logic/gofc_pkg.sv
package gofc_pkg;
    localparam int NUM_OBJ = 16;
    localparam int IDX_W   = 4;
    localparam int TMO_W   = 16;
    localparam logic [TMO_W-1:0] TMO_RESET = 16'h03e8;

    // status byte layout
    localparam int BIT_TMO = 7;
    localparam int BIT_CHG = 4;
    localparam int BIT_UPD = 3;
    localparam int BIT_RD  = 2;
    localparam int TX_LO   = 0;
    localparam int TX_HI   = 1;

    localparam logic [1:0] TX_IDLE = 2'h0;
    localparam logic [1:0] TX_REQ  = 2'h1;
    localparam logic [1:0] TX_BUSY = 2'h2;
    localparam logic [1:0] TX_ERR  = 2'h3;

    typedef enum logic [3:0] {
        GOFC_CMD_SEND_VALUE = 4'h1,
        GOFC_CMD_REQ_VALUE  = 4'h2,
        GOFC_CMD_GET_FLAGS  = 4'h3,
        GOFC_CMD_ALL_UPD    = 4'h4,
        GOFC_CMD_ALL_CHG    = 4'h5,
        GOFC_CMD_ALL_TMO    = 4'h6,
        GOFC_CMD_DATA_READ  = 4'h7
    } gofc_cmd_type;

    typedef enum logic [1:0] {
        GOFC_ST_IDLE = 2'b00,
        GOFC_ST_RESP = 2'b01
    } gofc_state_type;

    typedef struct packed {
        logic              valid;
        gofc_cmd_type      cmd;
        logic [IDX_W-1:0]  object_index;
        logic [7:0]        value;
    } gofc_rx_type;

    typedef struct packed {
        logic              valid;
        gofc_cmd_type      cmd;
        logic [IDX_W-1:0]  object_index;
        logic [NUM_OBJ-1:0] data;
    } gofc_resp_type;

    typedef struct packed {
        logic              valid;
        logic              read_req;
        logic [IDX_W-1:0]  object_index;
        logic [7:0]        value;
    } gofc_tx_type;

    typedef struct packed {
        gofc_state_type              state;
        logic [NUM_OBJ-1:0][7:0]     flags;
        logic [NUM_OBJ-1:0][7:0]     values;
        logic [NUM_OBJ-1:0][TMO_W-1:0] tmo_cnt;
        gofc_resp_type               resp;
        gofc_tx_type                 tx;
    } gofc_state_all_type;
endpackage

// ===== test/gofc_bus_model.sv
`timescale 1ns/1ps
module gofc_bus_model (
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire gofc_pkg::gofc_tx_type tx_out,
    output logic                       tx_ready,
    output logic                       tx_done,
    output gofc_pkg::gofc_tx_type      last_tx
);
    import gofc_pkg::*;
    logic [1:0] wait_q;
    // stall count advances only while a telegram waits and wraps to 0 at each grant, so every grant comes on the fourth waiting cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_ready <= 1'b0;
            tx_done  <= 1'b0;
            last_tx  <= '0;
            wait_q   <= 2'h0;
        end else begin
            tx_done  <= tx_ready;
            tx_ready <= 1'b0;
            if (tx_out.valid && !tx_ready) begin
                wait_q <= wait_q + 2'h1;
                if (wait_q == 2'h3) begin
                    tx_ready <= 1'b1;
                    last_tx  <= tx_out;
                end
            end
        end
    end
endmodule

// ===== test/gofc_core_properties.sv
`timescale 1ns/1ps
module gofc_core_properties (
    input wire logic                    clk_sys,
    input wire logic                    reset_n,
    input wire gofc_pkg::gofc_rx_type   cmd_in,
    input wire logic                    cmd_ready,
    input wire gofc_pkg::gofc_resp_type resp_out,
    input wire logic                    resp_ack,
    input wire gofc_pkg::gofc_tx_type   tx_out,
    input wire logic                    tx_ready
);
    import gofc_pkg::*;
    logic take;
    assign take = cmd_in.valid && cmd_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_resp_next: assert property (take |=> resp_out.valid) else $error("no reply");
    a_resp_echo: assert property (take |=> resp_out.cmd == $past(cmd_in.cmd) &&
        resp_out.object_index == $past(cmd_in.object_index)) else $error("bad echo");
    a_resp_hold: assert property (resp_out.valid && !resp_ack |=> $stable(resp_out))
        else $error("reply moved");
    a_busy_ready: assert property (resp_out.valid |-> !cmd_ready) else $error("ready");
    a_send_write: assert property (take && cmd_in.cmd == GOFC_CMD_SEND_VALUE |->
        ##[1:3] tx_out.valid && !tx_out.read_req) else $error("no write telegram");
    a_req_read: assert property (take && cmd_in.cmd == GOFC_CMD_REQ_VALUE |->
        ##[1:3] tx_out.valid && tx_out.read_req) else $error("no read telegram");
    a_tx_hold: assert property (tx_out.valid && !tx_ready |=> $stable(tx_out))
        else $error("telegram moved");
    a_flag_unused: assert property (resp_out.valid && resp_out.cmd == GOFC_CMD_GET_FLAGS
        |-> resp_out.data[15:8] == 8'h00 && resp_out.data[6:5] == 2'h0) else $error("unused");
endmodule
bind gofc_core gofc_core_properties u_props (.clk_sys, .reset_n, .cmd_in, .cmd_ready,
    .resp_out, .resp_ack, .tx_out, .tx_ready);

// ===== test/gofc_core_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module gofc_core_tb;
    import gofc_pkg::*;
    logic               clk_sys = 1'b0, reset_n = 1'b0, resp_ack = 1'b0, bus_rx_valid = 1'b0;
    gofc_rx_type        cmd_in = '0;
    logic [3:0]         bus_rx_index = 4'h0, i;
    logic [7:0]         bus_rx_value = 8'h00, v, exp_val [NUM_OBJ];
    logic               cmd_ready, tx_ready, tx_done;
    gofc_resp_type      resp_out;
    gofc_tx_type        tx_out, last_tx;
    logic [NUM_OBJ-1:0] exp_upd = '0, exp_chg = '0, seen = '0, d;
    logic [31:0]        rnd = 32'd84431;
    int                 failures = 0, comparisons = 0, n;
    always #50 clk_sys = ~clk_sys;
    gofc_core u_dut (.clk_sys, .reset_n, .cmd_in, .cmd_ready, .resp_out, .resp_ack, .tx_out,
        .tx_ready, .tx_done, .tx_fail(1'b0), .bus_rx_valid, .bus_rx_index, .bus_rx_value);
    gofc_bus_model u_bus (.clk_sys, .reset_n, .tx_out, .tx_ready, .tx_done, .last_tx);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_of_test();
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick();
        @(negedge clk_sys);
        if (++n > 2000) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic run(input gofc_cmd_type c, input logic [3:0] x);
        n = 0;
        tick();
        while (cmd_ready !== 1'b1) tick();
        @(posedge clk_sys);
        cmd_in <= '{1'b1, c, x, 8'h00};
        @(posedge clk_sys);
        cmd_in <= '0;
        tick();
        while (resp_out.valid !== 1'b1) tick();
        d = resp_out.data;
        @(posedge clk_sys);
        resp_ack <= 1'b1;
        @(posedge clk_sys);
        resp_ack <= 1'b0;
    endtask
    initial begin
        foreach (exp_val[k]) exp_val[k] = 8'h00;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        // every counter starts at the full timeout, so all objects expire together
        repeat (1010) @(posedge clk_sys);
        run(GOFC_CMD_ALL_TMO, 4'h0);
        `CHK("tmo_all", 16'hffff, d)
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            i = rnd[3:0];
            v = k[0] ? exp_val[i] : rnd[11:4];
            @(posedge clk_sys);
            bus_rx_valid <= 1'b1;
            bus_rx_index <= i;
            bus_rx_value <= v;
            @(posedge clk_sys);
            bus_rx_valid <= 1'b0;
            exp_chg[i] = exp_chg[i] | (v != exp_val[i]);
            exp_val[i] = v;
            exp_upd[i] = 1'b1;
            seen[i] = 1'b1;
            run(GOFC_CMD_GET_FLAGS, i);
            `CHK("flags", {3'h0, exp_chg[i], 4'h8}, d[7:0])
            run(GOFC_CMD_ALL_UPD, 4'h0);
            `CHK("upd_all", exp_upd, d)
            run(GOFC_CMD_ALL_CHG, 4'h0);
            `CHK("chg_all", exp_chg, d)
            run(GOFC_CMD_ALL_TMO, 4'h0);
            `CHK("tmo_all", ~seen, d)
            if (k % 3 == 2) begin
                run(GOFC_CMD_DATA_READ, i);
                `CHK("data", exp_val[i], d[7:0])
                exp_upd[i] = 1'b0;
            end
            run(k[0] ? GOFC_CMD_SEND_VALUE : GOFC_CMD_REQ_VALUE, i);
            while (cmd_ready !== 1'b1) tick();
            `CHK("tx", {~k[0], i}, {last_tx.read_req, last_tx.object_index})
            if (k[0]) `CHK("tx_val", exp_val[i], last_tx.value)
        end
        end_of_test();
    end
endmodule
